// File: bench/hvpp_programmer.sv
`timescale 1ns/1ps
module hvpp_programmer (
   // Clock
   input wire logic clk,
   // Device status and bus
   input wire logic ready_busy_n,
   input wire logic dut_drives,
   input wire logic [7:0] bus,
   // Strobes and selects
   output logic load_strobe,
   output logic page_latch_strobe,
   output logic write_strobe_n,
   output logic output_enable_n,
   output logic action_select_hi,
   output logic action_select_lo,
   output logic byte_select_low,
   output logic byte_select_high,
   // Bus drive
   output logic [7:0] drive_data
);
   logic [7:0] held = 8'h00;
   logic released = 1'b0;

   // Released bus shows a changed value, never a stale one
   assign drive_data = released ? ~held : held;

   initial
   begin
      load_strobe = 1'b0;
      page_latch_strobe = 1'b0;
      write_strobe_n = 1'b1;
      output_enable_n = 1'b1;
      {action_select_hi, action_select_lo} = 2'h3;
      byte_select_low = 1'b0;
      byte_select_high = 1'b0;
   end

   task automatic gap(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Selects and data settle well before and after each edge
   task automatic load(input logic [1:0] act, input logic bsl, input logic [7:0] d);
      @(posedge clk);
      {action_select_hi, action_select_lo} <= act;
      byte_select_low <= bsl;
      held <= d;
      released <= 1'b0;
      gap(4);
      load_strobe <= 1'b1;
      gap(4);
      load_strobe <= 1'b0;
      gap(4);
   endtask

   task automatic latch();
      @(posedge clk);
      byte_select_low <= 1'b1;
      gap(4);
      page_latch_strobe <= 1'b1;
      gap(4);
      page_latch_strobe <= 1'b0;
      gap(4);
   endtask

   // Returns cycles seen busy, or -1 when busy never ends
   task automatic write(input logic bsh, input logic bsl, output int cnt);
      int i;
      cnt = 0;
      @(posedge clk);
      byte_select_high <= bsh;
      byte_select_low <= bsl;
      gap(4);
      write_strobe_n <= 1'b0;
      for (i = 0; i < 6000; i++)
      begin
         @(posedge clk);
         if (i == 4) write_strobe_n <= 1'b1;
         // Ready is looked at mid-cycle, clear of the edge that moves it
         @(negedge clk);
         if (ready_busy_n === 1'b0) cnt++;
         else if (cnt > 0 || i > 40) break;
      end
      if (i == 6000) cnt = -1;
      @(posedge clk);
      byte_select_high <= 1'b0;
      gap(4);
   endtask

   // Load given inside the busy time of a write; the port has to drop it
   task automatic write_then_load(input logic [1:0] act, input logic bsl, input logic [7:0] d);
      @(posedge clk);
      byte_select_low <= 1'b0;
      gap(4);
      write_strobe_n <= 1'b0;
      gap(5);
      write_strobe_n <= 1'b1;
      {action_select_hi, action_select_lo} <= act;
      byte_select_low <= bsl;
      held <= d;
      released <= 1'b0;
      gap(4);
      load_strobe <= 1'b1;
      gap(4);
      load_strobe <= 1'b0;
      gap(14);
   endtask

   task automatic read(input logic bsh, input logic bsl, output logic [7:0] v, output logic oe);
      @(posedge clk);
      byte_select_high <= bsh;
      byte_select_low <= bsl;
      output_enable_n <= 1'b0;
      released <= 1'b1;
      gap(5);
      @(negedge clk);
      v = bus;
      oe = dut_drives;
      @(posedge clk);
      output_enable_n <= 1'b1;
      gap(5);
   endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int PROG_N = 20;
   localparam int FUSE_N = 5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic load_strobe, page_latch_strobe, write_strobe_n, output_enable_n;
   logic action_select_hi, action_select_lo, byte_select_low, byte_select_high;
   logic [7:0] data_out, drive_data, bus, rv;
   logic data_oe, ready_busy_n, oe_seen;
   int err_total = 0;
   int cmp_count = 0;
   int busy;

   assign bus = data_oe ? data_out : drive_data;

   initial
   begin
      forever #20 clk = ~clk;
   end

   hvpp_port #(.PROG_WORDS_LOG2(8), .PROG_PAGE_LOG2(2), .DATA_BYTES_LOG2(6), .DATA_PAGE_LOG2(2),
      .PROG_CYCLES(PROG_N), .FUSE_CYCLES(FUSE_N)) i_dut (
      .clk(clk), .rst(rst), .load_strobe(load_strobe), .page_latch_strobe(page_latch_strobe),
      .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
      .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
      .byte_select_low(byte_select_low), .byte_select_high(byte_select_high),
      .data_in(bus), .data_out(data_out), .data_oe(data_oe), .ready_busy_n(ready_busy_n));

   hvpp_programmer i_prog (
      .clk(clk), .ready_busy_n(ready_busy_n), .dut_drives(data_oe), .bus(bus),
      .load_strobe(load_strobe), .page_latch_strobe(page_latch_strobe),
      .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
      .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
      .byte_select_low(byte_select_low), .byte_select_high(byte_select_high),
      .drive_data(drive_data));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Zero expected cycles means the strobe must leave ready high
   task automatic do_write(input logic bsh, input logic bsl, input int n);
      i_prog.write(bsh, bsl, busy);
      if (busy < 0)
      begin
         err_total++;
         wrap_up();
      end
      else
         check({7'h0, (n == 0) ? (busy == 0) : (busy >= n - 1 && busy <= n + 1)}, 8'h01, "busy length");
   endtask

   task automatic cmd(input logic [7:0] c);
      i_prog.load(hvpp_pkg::ACT_CMD, 1'b0, c);
   endtask

   task automatic addr(input logic bsl, input logic [7:0] a);
      i_prog.load(hvpp_pkg::ACT_ADDR, bsl, a);
   endtask

   task automatic dat(input logic bsl, input logic [7:0] d);
      i_prog.load(hvpp_pkg::ACT_DATA, bsl, d);
   endtask

   task automatic rd(input logic bsh, input logic bsl, input logic [7:0] exp, input string what);
      i_prog.read(bsh, bsl, rv, oe_seen);
      check({7'h0, oe_seen}, 8'h01, "bus driven");
      check(rv, exp, what);
      check({7'h0, data_oe}, 8'h00, "bus released");
   endtask

   task automatic put_word(input logic [7:0] a, input logic [15:0] w);
      addr(1'b0, a);
      dat(1'b0, w[7:0]);
      dat(1'b1, w[15:8]);
      i_prog.latch();
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      check({7'h0, ready_busy_n}, 8'h01, "ready in reset");
      check({7'h0, data_oe}, 8'h00, "bus idle in reset");
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cmd(hvpp_pkg::CMD_WR_PROG);
      addr(1'b1, 8'h00);
      put_word(8'h00, 16'h1234);
      put_word(8'h01, 16'hbeef);
      do_write(1'b0, 1'b0, PROG_N);
      put_word(8'h05, 16'h0a0b);
      do_write(1'b0, 1'b0, PROG_N);
      cmd(hvpp_pkg::CMD_NOP);
      do_write(1'b0, 1'b0, 0);
      cmd(hvpp_pkg::CMD_RD_PROG);
      addr(1'b0, 8'h01);
      rd(1'b0, 1'b0, 8'hef, "flash low");
      rd(1'b0, 1'b1, 8'hbe, "flash high");
      addr(1'b0, 8'h05);
      rd(1'b0, 1'b0, 8'h0b, "flash page one low");
      rd(1'b0, 1'b1, 8'h0a, "flash page one high");
      addr(1'b0, 8'h00);
      rd(1'b0, 1'b1, 8'h12, "flash word zero");
      cmd(hvpp_pkg::CMD_WR_DATA);
      addr(1'b1, 8'h00);
      addr(1'b0, 8'h06);
      dat(1'b0, 8'h3c);
      i_prog.latch();
      do_write(1'b0, 1'b0, PROG_N);
      i_prog.write_then_load(hvpp_pkg::ACT_ADDR, 1'b0, 8'h07);
      cmd(hvpp_pkg::CMD_RD_DATA);
      rd(1'b0, 1'b0, 8'h3c, "data memory");
      cmd(hvpp_pkg::CMD_WR_FUSE);
      dat(1'b0, 8'ha5);
      do_write(1'b0, 1'b0, FUSE_N);
      dat(1'b0, 8'h5a);
      do_write(1'b0, 1'b1, FUSE_N);
      dat(1'b0, 8'h77);
      do_write(1'b1, 1'b0, FUSE_N);
      cmd(8'h55);
      dat(1'b0, 8'h00);
      do_write(1'b0, 1'b0, 0);
      cmd(hvpp_pkg::CMD_WR_LOCK);
      dat(1'b0, 8'hfc);
      do_write(1'b0, 1'b0, FUSE_N);
      dat(1'b0, 8'hc3);
      do_write(1'b0, 1'b0, FUSE_N);
      cmd(hvpp_pkg::CMD_RD_FUSE);
      rd(1'b0, 1'b0, 8'ha5, "fuse low");
      rd(1'b1, 1'b1, 8'h5a, "fuse high");
      rd(1'b1, 1'b0, 8'h77, "fuse extended");
      rd(1'b0, 1'b1, 8'hfc, "lock byte");
      cmd(hvpp_pkg::CMD_RD_ID);
      addr(1'b0, 8'h00);
      rd(1'b0, 1'b0, hvpp_pkg::ID_BYTE0, "id byte zero");
      rd(1'b0, 1'b1, hvpp_pkg::CAL_BYTE, "calibration");
      addr(1'b0, 8'h01);
      rd(1'b0, 1'b0, hvpp_pkg::ID_BYTE1, "id byte one");
      addr(1'b0, 8'h02);
      i_prog.load(hvpp_pkg::ACT_CMD, 1'b1, hvpp_pkg::CMD_RD_PROG);
      i_prog.load(hvpp_pkg::ACT_IDLE, 1'b0, 8'h00);
      rd(1'b0, 1'b0, hvpp_pkg::ID_BYTE2, "id byte two");
      wrap_up();
   end
endmodule

// File: design/hvpp_pkg.sv
package hvpp_pkg;
   // Command codes
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_WR_PROG = 8'h10;
   localparam logic [7:0] CMD_WR_DATA = 8'h11;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK = 8'h20;
   localparam logic [7:0] CMD_RD_PROG = 8'h02;
   localparam logic [7:0] CMD_RD_DATA = 8'h03;
   localparam logic [7:0] CMD_RD_FUSE = 8'h04;
   localparam logic [7:0] CMD_RD_ID = 8'h08;
   // Action select coding
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;
   // Reset values of the nonvolatile bytes (unprogrammed reads as one)
   localparam logic [7:0] FUSE_LOW_RST = 8'hff;
   localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
   localparam logic [7:0] FUSE_EXT_RST = 8'hff;
   localparam logic [7:0] LOCK_RST = 8'hff;
   // Lock byte fields
   localparam int LOCK_MODE_A_POS = 0;
   localparam int LOCK_MODE_B_POS = 1;
   localparam logic [7:0] BOOT_LOCK_MASK = 8'h3c;
   // Identification bytes, values arbitrary
   localparam logic [7:0] ID_BYTE0 = 8'h5a;
   localparam logic [7:0] ID_BYTE1 = 8'h01;
   localparam logic [7:0] ID_BYTE2 = 8'h02;
   localparam logic [7:0] CAL_BYTE = 8'h80;
   // Programming times
   localparam int CLK_MHZ = 25;
   localparam int T_PROG_US = 100;
   localparam int T_FUSE_US = 20;
   localparam int PROG_CYCLES = T_PROG_US * CLK_MHZ;
   localparam int FUSE_CYCLES = T_FUSE_US * CLK_MHZ;
endpackage

// File: design/hvpp_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Action select 10, low byte select 0: load strobe captures command byte.
// - Action select 00: load strobe captures address low or high per byte select.
// - Action select 01: load strobe captures data low or high per byte select.
// - Page-latch strobe writes data into buffer word; flash needs byte select low high.
// - Low address bits pick word in page; upper bits pick the page.
// - Write strobe under program write command programs page, ready low meanwhile.
// - Command 0x10 selects program memory page writes.
// - Command 0x00 is no operation and clears the write session.
// - Command 0x11 fills data memory buffer; write strobe with byte select low 0 programs that page.
// - Command 0x02 reads program word low or high byte under output enable.
// - Command 0x03 reads addressed data memory byte under output enable.
// - Command 0x40: loaded low data byte sets fuses, zero programs.
// - Byte selects choose low, high or extended fuse byte at write.
// - Command 0x20: write strobe programs lock bits loaded as zero, then busy.
// - Lock mode 3 blocks programming of boot lock bits.
// - Lock bits return unprogrammed only through reset.
// - Command 0x04 reads fuse low, high, extended or lock per byte selects.
// - Command 0x08 with byte select low 0 reads id byte at address 0..2.
// - Command 0x08, address 0, byte select low 1 reads calibration byte.
// - Data bus driven only while output enable is low.
// - Command and address are kept across operations.
// - Ready is low while busy and high when a command may be given.
module hvpp_port #(
   parameter int PROG_WORDS_LOG2 = 14,
   parameter int PROG_PAGE_LOG2 = 6,
   parameter int DATA_BYTES_LOG2 = 10,
   parameter int DATA_PAGE_LOG2 = 2,
   parameter int PROG_CYCLES = hvpp_pkg::PROG_CYCLES,
   parameter int FUSE_CYCLES = hvpp_pkg::FUSE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Programmer strobes and selects (asynchronous pins)
   input wire logic load_strobe,
   input wire logic page_latch_strobe,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic action_select_hi,
   input wire logic action_select_lo,
   input wire logic byte_select_low,
   input wire logic byte_select_high,
   // Data bus split into three signals
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   // Status
   output logic ready_busy_n
);
   localparam int PW = PROG_WORDS_LOG2;
   localparam int DW = DATA_BYTES_LOG2;

   // Synchronised pin inputs
   logic [7:0] pins_s;
   logic [7:0] data_s;
   hvpp_sync #(.W(8)) u_sync_ctl (
      .clk(clk),
      .rst(rst),
      .d({load_strobe, page_latch_strobe, ~write_strobe_n, ~output_enable_n,
          action_select_hi, action_select_lo, byte_select_low, byte_select_high}),
      .q(pins_s)
   );
   hvpp_sync #(.W(8)) u_sync_dat (
      .clk(clk),
      .rst(rst),
      .d(data_in),
      .q(data_s)
   );
   wire load_s = pins_s[7];
   wire latch_s = pins_s[6];
   wire wr_s = pins_s[5];
   wire oe_s = pins_s[4];
   wire [1:0] act_s = pins_s[3:2];
   wire bsl_s = pins_s[1];
   wire bsh_s = pins_s[0];

   // Edge detection on synchronised strobes
   logic load_d_r;
   logic latch_d_r;
   logic wr_d_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         load_d_r <= 1'b0;
         latch_d_r <= 1'b0;
         wr_d_r <= 1'b0;
      end
      else
      begin
         load_d_r <= load_s;
         latch_d_r <= latch_s;
         wr_d_r <= wr_s;
      end
   end

   logic busy;
   logic done;
   // Strobes are dropped while a program cycle runs
   wire idle = !busy;
   wire load_p = load_s && !load_d_r && idle;
   wire latch_p = latch_s && !latch_d_r && idle;
   wire wr_p = wr_s && !wr_d_r && idle;

   // Loaded command, address and data
   logic [7:0] cmd_r;
   logic [7:0] addr_lo_r;
   logic [7:0] addr_hi_r;
   logic [7:0] data_lo_r;
   logic [7:0] data_hi_r;
   wire ld_cmd = load_p && act_s == hvpp_pkg::ACT_CMD && !bsl_s;
   wire ld_addr = load_p && act_s == hvpp_pkg::ACT_ADDR;
   wire ld_data = load_p && act_s == hvpp_pkg::ACT_DATA;
   // Idle coding takes no load; decoded only so the check below can watch it
   wire ld_none = load_p && act_s == hvpp_pkg::ACT_IDLE;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cmd_r <= hvpp_pkg::CMD_NOP;
         addr_lo_r <= 8'h00;
         addr_hi_r <= 8'h00;
         data_lo_r <= 8'hff;
         data_hi_r <= 8'hff;
      end
      else
      begin
         if (ld_cmd)
            cmd_r <= data_s;
         if (ld_addr && !bsl_s)
            addr_lo_r <= data_s;
         if (ld_addr && bsl_s)
            addr_hi_r <= data_s;
         if (ld_data && !bsl_s)
            data_lo_r <= data_s;
         if (ld_data && bsl_s)
            data_hi_r <= data_s;
      end
   end

   wire [15:0] addr = {addr_hi_r, addr_lo_r};
   wire is_wprog = cmd_r == hvpp_pkg::CMD_WR_PROG;
   wire is_wdata = cmd_r == hvpp_pkg::CMD_WR_DATA;
   wire is_wfuse = cmd_r == hvpp_pkg::CMD_WR_FUSE;
   wire is_wlock = cmd_r == hvpp_pkg::CMD_WR_LOCK;

   // Memories and page buffers
   logic [15:0] prog_mem [0:(1<<PW)-1];
   logic [7:0] data_mem [0:(1<<DW)-1];
   logic [15:0] prog_buf [0:(1<<PROG_PAGE_LOG2)-1];
   logic [7:0] data_buf [0:(1<<DATA_PAGE_LOG2)-1];
   logic [(1<<DATA_PAGE_LOG2)-1:0] data_buf_v_r;

   // Word within page from low bits, page from the rest
   wire [PROG_PAGE_LOG2-1:0] word_in_page = addr[PROG_PAGE_LOG2-1:0];
   wire [PW-PROG_PAGE_LOG2-1:0] page_index = addr[PW-1:PROG_PAGE_LOG2];
   wire [DATA_PAGE_LOG2-1:0] data_word_in_page = addr[DATA_PAGE_LOG2-1:0];
   wire [DW-DATA_PAGE_LOG2-1:0] data_page_index = addr[DW-1:DATA_PAGE_LOG2];

   // Buffer fill; flash needs byte select low high, data memory takes low byte
   always_ff @(posedge clk)
   begin
      if (latch_p && bsl_s && is_wprog)
         prog_buf[word_in_page] <= {data_hi_r, data_lo_r};
      if (latch_p && is_wdata)
         data_buf[data_word_in_page] <= data_lo_r;
   end

   // Pending page session
   logic wsess_r;
   wire cmd_nop = ld_cmd && data_s == hvpp_pkg::CMD_NOP;
   always_ff @(posedge clk)
   begin
      if (rst || cmd_nop)
      begin
         wsess_r <= 1'b0;
         data_buf_v_r <= '0;
      end
      else
      begin
         if (latch_p && (is_wprog || is_wdata))
            wsess_r <= 1'b1;
         if (latch_p && is_wdata)
            data_buf_v_r[data_word_in_page] <= 1'b1;
         else if (done && is_wdata)
            data_buf_v_r <= '0;
      end
   end

   // Fuse and lock bytes
   logic [7:0] fuse_lo_r;
   logic [7:0] fuse_hi_r;
   logic [7:0] fuse_ext_r;
   logic [7:0] lock_r;
   wire lock_mode3 = !lock_r[hvpp_pkg::LOCK_MODE_A_POS] && !lock_r[hvpp_pkg::LOCK_MODE_B_POS];
   // Boot lock bits frozen in mode 3; lock bits only ever go to zero here
   wire [7:0] lock_keep = lock_mode3 ? hvpp_pkg::BOOT_LOCK_MASK : 8'h00;
   wire [7:0] lock_nxt = lock_r & (data_lo_r | lock_keep);

   // Write strobe dispatch; other commands start nothing
   wire start_prog = wr_p && is_wprog;
   wire start_data = wr_p && is_wdata && !bsl_s;
   wire start_fuse = wr_p && is_wfuse;
   wire start_lock = wr_p && is_wlock;
   wire start_any = start_prog || start_data || start_fuse || start_lock;
   wire long_op = start_prog || start_data;

   // Which page commit the running busy period ends in
   typedef enum logic [2:0] {OP_IDLE = 3'b001, OP_PROG = 3'b010, OP_DATA = 3'b100} hvpp_op_t;
   hvpp_op_t op_r;
   hvpp_op_t op_nxt;
   always_comb
   begin
      op_nxt = op_r;
      case (op_r)
         OP_IDLE:
         begin
            if (start_prog)
               op_nxt = OP_PROG;
            else if (start_data)
               op_nxt = OP_DATA;
         end
         default:
         begin
            if (done)
               op_nxt = OP_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         op_r <= OP_IDLE;
      else
         op_r <= op_nxt;
   end

   hvpp_timer #(.CW(24)) u_timer (
      .clk(clk),
      .rst(rst),
      .start(start_any),
      .cycles(long_op ? 24'(PROG_CYCLES) : 24'(FUSE_CYCLES)),
      .busy(busy),
      .done(done)
   );

   // Page commit at end of the busy period
   integer i;
   always_ff @(posedge clk)
   begin
      if (done && op_r == OP_PROG)
      begin
         for (i = 0; i < (1<<PROG_PAGE_LOG2); i = i + 1)
            prog_mem[{page_index, i[PROG_PAGE_LOG2-1:0]}] <= prog_buf[i];
      end
      if (done && op_r == OP_DATA)
      begin
         for (i = 0; i < (1<<DATA_PAGE_LOG2); i = i + 1)
            if (data_buf_v_r[i])
               data_mem[{data_page_index, i[DATA_PAGE_LOG2-1:0]}] <= data_buf[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fuse_lo_r <= hvpp_pkg::FUSE_LOW_RST;
         fuse_hi_r <= hvpp_pkg::FUSE_HIGH_RST;
         fuse_ext_r <= hvpp_pkg::FUSE_EXT_RST;
         lock_r <= hvpp_pkg::LOCK_RST;
      end
      else
      begin
         if (start_fuse && !bsh_s && !bsl_s)
            fuse_lo_r <= data_lo_r;
         if (start_fuse && !bsh_s && bsl_s)
            fuse_hi_r <= data_lo_r;
         if (start_fuse && bsh_s && !bsl_s)
            fuse_ext_r <= data_lo_r;
         if (start_lock)
            lock_r <= lock_nxt;
      end
   end

   // Read data selection
   wire [15:0] prog_word = prog_mem[addr[PW-1:0]];
   wire [7:0] fl_sel = !bsh_s ? (bsl_s ? lock_r : fuse_lo_r)
                              : (bsl_s ? fuse_hi_r : fuse_ext_r);
   wire [7:0] id_sel = (addr_lo_r == 8'h00) ? hvpp_pkg::ID_BYTE0 :
                       (addr_lo_r == 8'h01) ? hvpp_pkg::ID_BYTE1 :
                       (addr_lo_r == 8'h02) ? hvpp_pkg::ID_BYTE2 : 8'h00;
   wire rd_id_cal = bsl_s && addr_lo_r == 8'h00;
   wire [7:0] rd_nxt = (cmd_r == hvpp_pkg::CMD_RD_PROG) ? (bsl_s ? prog_word[15:8] : prog_word[7:0]) :
                       (cmd_r == hvpp_pkg::CMD_RD_DATA) ? data_mem[addr[DW-1:0]] :
                       (cmd_r == hvpp_pkg::CMD_RD_FUSE) ? fl_sel :
                       (cmd_r == hvpp_pkg::CMD_RD_ID) ? (rd_id_cal ? hvpp_pkg::CAL_BYTE : id_sel) : 8'h00;
   wire rd_cmd = cmd_r == hvpp_pkg::CMD_RD_PROG || cmd_r == hvpp_pkg::CMD_RD_DATA ||
                 cmd_r == hvpp_pkg::CMD_RD_FUSE || cmd_r == hvpp_pkg::CMD_RD_ID;
   // Bus released on output enable high regardless of command
   wire oe_nxt = oe_s && rd_cmd;

   logic [7:0] dout_r;
   logic oe_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dout_r <= 8'h00;
         oe_r <= 1'b0;
      end
      else
      begin
         dout_r <= rd_nxt;
         oe_r <= oe_nxt;
      end
   end
   assign data_out = dout_r;
   assign data_oe = oe_r;
   assign ready_busy_n = !busy;

   a_cmd_load: assert property (@(posedge clk) disable iff (rst)
      ld_cmd |=> cmd_r == $past(data_s)) else $error("command not captured");
   a_addr_low: assert property (@(posedge clk) disable iff (rst)
      ld_addr && !bsl_s |=> addr_lo_r == $past(data_s)) else $error("address low not captured");
   a_data_high: assert property (@(posedge clk) disable iff (rst)
      ld_data && bsl_s |=> data_hi_r == $past(data_s)) else $error("data high not captured");
   a_prog_busy: assert property (@(posedge clk) disable iff (rst)
      start_prog |=> !ready_busy_n [*3]) else $error("busy not shown after write");
   a_data_busy: assert property (@(posedge clk) disable iff (rst)
      start_data |=> !ready_busy_n [*3]) else $error("busy not shown after data write");
   a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
      busy && load_s && !load_d_r |=> $stable({cmd_r, addr_hi_r, addr_lo_r, data_hi_r, data_lo_r}))
      else $error("load taken while busy");
   a_idle_load: assert property (@(posedge clk) disable iff (rst)
      ld_none |=> $stable({cmd_r, addr_hi_r, addr_lo_r, data_hi_r, data_lo_r})) else $error("idle load took effect");
   a_bus_release: assert property (@(posedge clk) disable iff (rst)
      !oe_s |=> !data_oe) else $error("bus driven without output enable");
   a_fuse_low: assert property (@(posedge clk) disable iff (rst)
      start_fuse && !bsh_s && !bsl_s |=> fuse_lo_r == $past(data_lo_r)) else $error("fuse low not written");
   a_lock_mono: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> (lock_r & ~$past(lock_r)) == 8'h00) else $error("lock bit erased");
   a_nop_sess: assert property (@(posedge clk) disable iff (rst)
      cmd_nop |=> !wsess_r) else $error("session not ended");
   c_prog: cover property (@(posedge clk) start_prog);
   c_data: cover property (@(posedge clk) start_data);
   c_read: cover property (@(posedge clk) data_oe);
   c_fuse: cover property (@(posedge clk) start_fuse);
   c_busy_drop: cover property (@(posedge clk) busy && load_s && !load_d_r);
endmodule

// File: design/hvpp_sync.sv
`timescale 1ns/1ps
module hvpp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
   assign q = q_r;
endmodule

// File: design/hvpp_timer.sv
`timescale 1ns/1ps
module hvpp_timer #(
   parameter int CW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic [CW-1:0] cycles,
   output logic busy,
   output logic done
);
   logic [CW-1:0] cnt_r;
   logic busy_r;
   logic done_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         if (start && !busy_r)
         begin
            cnt_r <= cycles;
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            if (cnt_r <= 1)
            begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
   assign busy = busy_r;
   assign done = done_r;
endmodule
